//--- design/axis_channel.sv
`timescale 1ns/100ps
// One axis: applies scanned flags and drives the motor-facing outputs
module axis_channel
  import axis_flags_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scan_tick, // One-cycle pulse: scan boundary
  input wire logic [15:0] i_cmd, // Command word as applied this scan
  input wire logic [15:0] i_mcode_cfg,
  input wire logic [15:0] i_origin_cfg,
  input wire logic [15:0] i_out_cfg,
  input wire logic i_origin_req, // Start an origin search
  input wire logic i_step_done, // Motion of the current step finished
  input wire logic i_upper_limit, // Synchronised limit inputs
  input wire logic i_lower_limit,
  input wire logic i_sw_limit_hit, // Software limit exceeded
  input wire logic i_const_speed, // Axis is at constant speed
  input wire logic i_pulse_tick, // Pulse-rate enable
  output logic o_pulse_a, // CW or PLS line
  output logic o_pulse_b, // CCW or DIR line
  output logic o_mcode, // M-code signal
  output logic o_high_speed, // Jog speed in use
  output logic [3:0] o_status // Busy, jog, direction, limit
);
  axis_state_e state_ff, nxt_state;
  logic start_prev_ff, nxt_start_prev; // Start bit of previous scan
  logic dir_ff, nxt_dir; // 1 is backward
  logic phase_ff, nxt_phase; // Pulse toggle
  logic mcode_ff, nxt_mcode;
  logic limit_ff, nxt_limit;
  logic fwd, rev, enabled, limit_stop, sw_stop, start_edge;
  mcode_mode_e mmode;

  // Decode the applied flags
  always_comb
  begin
    fwd = i_cmd[CMD_FWD_JOG_BIT];
    rev = i_cmd[CMD_REV_JOG_BIT];
    enabled = !i_out_cfg[OUT_DISABLE_BIT];
    mmode = mcode_mode_e'(i_mcode_cfg[MCODE_LSB +: 2]);
    limit_stop = i_out_cfg[OUT_LIMIT_USE_BIT] && (i_upper_limit || i_lower_limit);
    sw_stop = i_mcode_cfg[SW_LIMIT_BIT] && i_const_speed && i_sw_limit_hit;
    start_edge = i_scan_tick && i_cmd[CMD_START_BIT] && !start_prev_ff;
  end

  // Next state of the axis
  always_comb
  begin
    nxt_state = state_ff;
    nxt_dir = dir_ff;
    nxt_phase = phase_ff;
    nxt_mcode = mcode_ff;
    nxt_limit = limit_stop || sw_stop;
    nxt_start_prev = i_scan_tick ? i_cmd[CMD_START_BIT] : start_prev_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (!enabled || limit_stop)
          nxt_state = ST_IDLE;
        else if (start_edge)
        begin
          nxt_state = ST_RUN;
          nxt_dir = 1'b0;
          nxt_mcode = (mmode == MCODE_WITH);
        end
        else if (fwd ^ rev)
        begin
          nxt_state = ST_JOG;
          nxt_dir = rev;
        end
        else if (i_origin_req)
        begin
          nxt_state = ST_ORIGIN;
          nxt_dir = i_origin_cfg[ORIGIN_DIR_BIT];
        end
      end
      ST_RUN:
      begin
        if (!enabled || limit_stop || sw_stop)
          nxt_state = ST_IDLE;
        else if (i_step_done)
        begin
          nxt_state = ST_IDLE;
          nxt_mcode = (mmode == MCODE_AFTER);
        end
      end
      ST_JOG:
      begin
        // Level-driven: stop on release, on reversal or with both directions set;
        // a reversal restarts from idle so the direction is taken afresh
        if (!(fwd ^ rev) || rev != dir_ff || !enabled || limit_stop || sw_stop)
          nxt_state = ST_IDLE;
      end
      ST_ORIGIN:
      begin
        if (!enabled || limit_stop || i_step_done)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (start_edge && mmode == MCODE_NONE)
      nxt_mcode = 1'b0;
    if (nxt_state != ST_IDLE && i_pulse_tick)
      nxt_phase = !phase_ff;
    else if (nxt_state == ST_IDLE)
      nxt_phase = 1'b0;
  end

  // Register the axis state
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state_ff <= ST_IDLE;
      start_prev_ff <= 1'b0;
      dir_ff <= 1'b0;
      phase_ff <= 1'b0;
      mcode_ff <= 1'b0;
      limit_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      start_prev_ff <= nxt_start_prev;
      dir_ff <= nxt_dir;
      phase_ff <= nxt_phase;
      mcode_ff <= nxt_mcode;
      limit_ff <= nxt_limit;
    end
  end

  // Output formatting: format select and polarity
  always_comb
  begin
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    if (i_out_cfg[OUT_FORMAT_BIT])
    begin
      a = phase_ff;
      b = dir_ff;
    end
    else
    begin
      a = phase_ff && !dir_ff;
      b = phase_ff && dir_ff;
    end
    // Active-low outputs idle high, except the direction line in pulse/direction format
    o_pulse_a = i_out_cfg[OUT_LEVEL_BIT] ? a : !a;
    o_pulse_b = i_out_cfg[OUT_LEVEL_BIT] ? b : !b;
    o_mcode = mcode_ff;
    o_high_speed = i_cmd[CMD_SPEED_BIT];
    o_status = {limit_ff, dir_ff, state_ff == ST_JOG, state_ff != ST_IDLE};
  end
endmodule

//--- design/axis_flags_pkg.sv
package axis_flags_pkg;
  // Register byte addresses, one aligned word each, axis X then axis Y
  localparam logic [5:0] ADDR_X_CMD = 6'h00;
  localparam logic [5:0] ADDR_X_MCODE_CFG = 6'h04;
  localparam logic [5:0] ADDR_X_ORIGIN_CFG = 6'h08;
  localparam logic [5:0] ADDR_X_OUT_CFG = 6'h0c;
  localparam logic [5:0] ADDR_X_STEP = 6'h10;
  localparam logic [5:0] ADDR_X_STATUS = 6'h14;
  localparam logic [5:0] ADDR_Y_BASE = 6'h20;
  localparam logic [5:0] ADDR_SCAN_CTRL = 6'h18;
  localparam logic [5:0] ADDR_AXIS_MASK = 6'h1c;
  // Command word fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_FWD_JOG_BIT = 1;
  localparam int CMD_REV_JOG_BIT = 2;
  localparam int CMD_SPEED_BIT = 3;
  // M-code and limit configuration fields
  localparam int MCODE_LSB = 1;
  localparam int SW_LIMIT_BIT = 4;
  // Origin configuration fields
  localparam int ORIGIN_DIR_BIT = 2;
  // Output configuration fields
  localparam int OUT_DISABLE_BIT = 0;
  localparam int OUT_LEVEL_BIT = 1;
  localparam int OUT_LIMIT_USE_BIT = 2;
  localparam int OUT_FORMAT_BIT = 3;
  // Status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_JOG_BIT = 1;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_LIMIT_BIT = 3;
  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] STEP_RESET = 16'h0001;
  // M-code output modes
  typedef enum logic [1:0] {
    MCODE_NONE = 2'h0,
    MCODE_WITH = 2'h1,
    MCODE_AFTER = 2'h2
  } mcode_mode_e;
  // Per-axis motion states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_JOG = 4'h4,
    ST_ORIGIN = 4'h8
  } axis_state_e;
  // Scan period default in clock cycles
  localparam int SCAN_CYCLES_DEFAULT = 1000;
endpackage

//--- design/axis_flags_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Flag writes apply only from next scan.
// - Start runs on rising edge of start bit.
// - Run lasts until step done; step number unused.
// - Step number read-only; changed by instruction only.
// - Forward jog runs while its bit is set.
// - Reverse jog runs while its bit is set.
// - Speed bit picks jog low or high.
// - M-code mode: none, with step, after step.
// - Software limit check only when enabled.
// - Origin search direction from origin bit.
// - Level bit sets pulse polarity.
// - Limit inputs watched only when enabled.
// - Format bit picks CW/CCW or pulse/direction.
// - Jog follows command level, stops on release.
// - Both jog bits set stops, no error.
module axis_flags_top
  import axis_flags_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEFAULT, // Cycles per scan
  parameter int PULSE_DIV = 25 // Cycles per pulse half period
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Classic Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Step number change instruction, one axis at a time
  input wire logic i_step_change, // One-cycle pulse
  input wire logic i_step_axis, // 0 X, 1 Y
  input wire logic [15:0] i_step_value,
  // Motion feedback per axis, index 0 is X
  input wire logic [1:0] i_origin_req,
  input wire logic [1:0] i_step_done,
  input wire logic [1:0] i_sw_limit_hit,
  input wire logic [1:0] i_const_speed,
  input wire logic [1:0] i_upper_limit_pin, // Asynchronous pins
  input wire logic [1:0] i_lower_limit_pin,
  output logic [1:0] o_pulse_a,
  output logic [1:0] o_pulse_b,
  output logic [1:0] o_mcode,
  output logic [1:0] o_high_speed,
  output logic o_scan_tick // Scan boundary pulse
);
  import axis_flags_pkg::*;

  logic [15:0] wr_cmd_ff [2], nxt_wr_cmd [2]; // Words as written by software
  logic [15:0] wr_mc_ff [2], nxt_wr_mc [2];
  logic [15:0] wr_org_ff [2], nxt_wr_org [2];
  logic [15:0] wr_out_ff [2], nxt_wr_out [2];
  logic [15:0] ap_cmd_ff [2], nxt_ap_cmd [2]; // Words applied this scan
  logic [15:0] ap_mc_ff [2], nxt_ap_mc [2];
  logic [15:0] ap_org_ff [2], nxt_ap_org [2];
  logic [15:0] ap_out_ff [2], nxt_ap_out [2];
  logic [15:0] step_ff [2], nxt_step [2]; // Current step numbers
  logic [31:0] scan_cnt_ff, nxt_scan_cnt;
  logic [15:0] pdiv_ff, nxt_pdiv;
  logic scan_hold_ff, nxt_scan_hold; // Software freezes scans
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [1:0] up_s1_ff, up_s2_ff, lo_s1_ff, lo_s2_ff; // Limit synchronisers
  logic [3:0] status [2];
  logic scan_tick, pulse_tick;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // Register index within an axis block
  function automatic logic [4:0] local_adr(input logic [5:0] a);
    local_adr = a[4:0];
  endfunction

  // Scan and pulse-rate dividers
  always_comb
  begin
    scan_tick = (scan_cnt_ff == 32'(SCAN_CYCLES - 1)) && !scan_hold_ff;
    pulse_tick = (pdiv_ff == 16'(PULSE_DIV - 1));
    nxt_scan_cnt = scan_hold_ff ? scan_cnt_ff : (scan_tick ? 32'h0 : scan_cnt_ff + 32'h1);
    nxt_pdiv = pulse_tick ? 16'h0 : pdiv_ff + 16'h1;
    o_scan_tick = scan_tick;
  end

  // Bus decode, writes and scan application
  always_comb
  begin
    logic axis;
    logic hit;
    logic req;
    axis = i_wb_adr[5];
    hit = 1'b0;
    req = i_wb_cyc && i_wb_stb && !ack_ff;
    nxt_ack = req;
    nxt_rdat = 32'h0;
    nxt_scan_hold = scan_hold_ff;
    for (int k = 0; k < 2; k++)
    begin
      nxt_wr_cmd[k] = wr_cmd_ff[k];
      nxt_wr_mc[k] = wr_mc_ff[k];
      nxt_wr_org[k] = wr_org_ff[k];
      nxt_wr_out[k] = wr_out_ff[k];
      nxt_step[k] = step_ff[k];
      // Snapshot taken at scan end, used during next scan
      nxt_ap_cmd[k] = scan_tick ? wr_cmd_ff[k] : ap_cmd_ff[k];
      nxt_ap_mc[k] = scan_tick ? wr_mc_ff[k] : ap_mc_ff[k];
      nxt_ap_org[k] = scan_tick ? wr_org_ff[k] : ap_org_ff[k];
      nxt_ap_out[k] = scan_tick ? wr_out_ff[k] : ap_out_ff[k];
    end
    // Step number moves only by the change instruction
    if (i_step_change)
      nxt_step[i_step_axis] = i_step_value;
    if (req)
    begin
      unique case (local_adr(i_wb_adr))
        ADDR_X_CMD[4:0]:
        begin
          hit = 1'b1;
          nxt_rdat = {16'h0, wr_cmd_ff[axis]};
          if (i_wb_we)
            nxt_wr_cmd[axis] = merge16(wr_cmd_ff[axis], i_wb_dat, i_wb_sel);
        end
        ADDR_X_MCODE_CFG[4:0]:
        begin
          hit = 1'b1;
          nxt_rdat = {16'h0, wr_mc_ff[axis]};
          if (i_wb_we)
            nxt_wr_mc[axis] = merge16(wr_mc_ff[axis], i_wb_dat, i_wb_sel);
        end
        ADDR_X_ORIGIN_CFG[4:0]:
        begin
          hit = 1'b1;
          nxt_rdat = {16'h0, wr_org_ff[axis]};
          if (i_wb_we)
            nxt_wr_org[axis] = merge16(wr_org_ff[axis], i_wb_dat, i_wb_sel);
        end
        ADDR_X_OUT_CFG[4:0]:
        begin
          hit = 1'b1;
          nxt_rdat = {16'h0, wr_out_ff[axis]};
          if (i_wb_we)
            nxt_wr_out[axis] = merge16(wr_out_ff[axis], i_wb_dat, i_wb_sel);
        end
        ADDR_X_STEP[4:0]:
        begin
          hit = 1'b1; // Read-only, writes ignored
          nxt_rdat = {16'h0, step_ff[axis]};
        end
        ADDR_X_STATUS[4:0]:
        begin
          hit = 1'b1;
          nxt_rdat = {28'h0, status[axis]};
        end
        ADDR_SCAN_CTRL[4:0]:
        begin
          hit = !axis;
          nxt_rdat = {31'h0, scan_hold_ff};
          if (i_wb_we && !axis && i_wb_sel[0])
            nxt_scan_hold = i_wb_dat[0];
        end
        default:
          hit = 1'b0;
      endcase
      if (!hit)
        nxt_rdat = 32'h0; // Unmapped reads return zero, writes dropped
    end
  end

  // Register all state
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      for (int k = 0; k < 2; k++)
      begin
        wr_cmd_ff[k] <= CFG_RESET;
        wr_mc_ff[k] <= CFG_RESET;
        wr_org_ff[k] <= CFG_RESET;
        wr_out_ff[k] <= CFG_RESET;
        ap_cmd_ff[k] <= CFG_RESET;
        ap_mc_ff[k] <= CFG_RESET;
        ap_org_ff[k] <= CFG_RESET;
        ap_out_ff[k] <= CFG_RESET;
        step_ff[k] <= STEP_RESET;
      end
      scan_cnt_ff <= 32'h0;
      pdiv_ff <= 16'h0;
      scan_hold_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
      up_s1_ff <= 2'h0;
      up_s2_ff <= 2'h0;
      lo_s1_ff <= 2'h0;
      lo_s2_ff <= 2'h0;
    end
    else
    begin
      wr_cmd_ff <= nxt_wr_cmd;
      wr_mc_ff <= nxt_wr_mc;
      wr_org_ff <= nxt_wr_org;
      wr_out_ff <= nxt_wr_out;
      ap_cmd_ff <= nxt_ap_cmd;
      ap_mc_ff <= nxt_ap_mc;
      ap_org_ff <= nxt_ap_org;
      ap_out_ff <= nxt_ap_out;
      step_ff <= nxt_step;
      scan_cnt_ff <= nxt_scan_cnt;
      pdiv_ff <= nxt_pdiv;
      scan_hold_ff <= nxt_scan_hold;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      up_s1_ff <= i_upper_limit_pin;
      up_s2_ff <= up_s1_ff;
      lo_s1_ff <= i_lower_limit_pin;
      lo_s2_ff <= lo_s1_ff;
    end
  end

  // Bus answer
  always_comb
  begin
    o_wb_ack = ack_ff;
    o_wb_dat = rdat_ff;
  end

  // One independent channel per axis
  for (genvar g = 0; g < 2; g++)
  begin : g_axis
    axis_channel u_axis (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_scan_tick(scan_tick),
      .i_cmd(ap_cmd_ff[g]),
      .i_mcode_cfg(ap_mc_ff[g]),
      .i_origin_cfg(ap_org_ff[g]),
      .i_out_cfg(ap_out_ff[g]),
      .i_origin_req(i_origin_req[g]),
      .i_step_done(i_step_done[g]),
      .i_upper_limit(up_s2_ff[g]),
      .i_lower_limit(lo_s2_ff[g]),
      .i_sw_limit_hit(i_sw_limit_hit[g]),
      .i_const_speed(i_const_speed[g]),
      .i_pulse_tick(pulse_tick),
      .o_pulse_a(o_pulse_a[g]),
      .o_pulse_b(o_pulse_b[g]),
      .o_mcode(o_mcode[g]),
      .o_high_speed(o_high_speed[g]),
      .o_status(status[g])
    );
  end
endmodule

//--- sim/axis_flags_assertions.sv
`timescale 1ns/100ps
// Port-level checks for the flag block, shadowing written words
module axis_flags_assertions
  import axis_flags_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYCLES_DEFAULT,
  parameter int PULSE_DIV = 25
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [5:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [1:0] o_pulse_a,
  input wire logic [1:0] o_pulse_b,
  input wire logic [1:0] o_high_speed,
  input wire logic o_scan_tick
);
  logic [1:0][15:0] cmd_pend_ff; // Written command words per axis
  logic [1:0][15:0] cmd_app_ff; // Copies applied at scan boundary
  logic [15:0] out_pend_ff; // Written X output configuration
  logic [15:0] out_app_ff;
  int gap_ff; // Cycles since last scan boundary
  logic hold_ff; // Scan counter frozen by software
  wire take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  wire x_off = out_app_ff[OUT_DISABLE_BIT] && !out_app_ff[OUT_FORMAT_BIT];
  wire x_both = cmd_app_ff[0][2:1] == 2'h3 && !cmd_app_ff[0][CMD_START_BIT];
  // Shadow registers follow writes and scan application
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      cmd_pend_ff <= '0;
      cmd_app_ff <= '0;
      out_pend_ff <= 16'h0000;
      out_app_ff <= 16'h0000;
      gap_ff <= 0;
      hold_ff <= 1'b0;
    end
    else
    begin
      if (take && i_wb_adr[4:0] == ADDR_X_CMD[4:0])
        cmd_pend_ff[i_wb_adr[5]] <= i_wb_dat[15:0];
      if (take && i_wb_adr == ADDR_X_OUT_CFG)
        out_pend_ff <= i_wb_dat[15:0];
      if (o_scan_tick)
      begin
        cmd_app_ff <= cmd_pend_ff;
        out_app_ff <= out_pend_ff;
      end
      if (take && i_wb_adr == ADDR_SCAN_CTRL)
        hold_ff <= i_wb_dat[0];
      // A frozen scan counter restarts the gap count
      gap_ff <= (o_scan_tick || hold_ff) ? 0 : gap_ff + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_speed_scan;
    o_high_speed != $past(o_high_speed) |-> $past(o_scan_tick);
  endproperty
  a_speed_scan: assert property (p_speed_scan) else $error("speed off scan");
  property p_tick_gap;
    gap_ff < SCAN_CYCLES;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("scan too long");
  property p_tick_once;
    o_scan_tick |=> !o_scan_tick;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("tick held");
  property p_speed_x;
    o_high_speed[0] == cmd_app_ff[0][CMD_SPEED_BIT];
  endproperty
  a_speed_x: assert property (p_speed_x) else $error("X speed wrong");
  property p_speed_y;
    o_high_speed[1] == cmd_app_ff[1][CMD_SPEED_BIT];
  endproperty
  a_speed_y: assert property (p_speed_y) else $error("Y speed wrong");
  property p_off_idle;
    x_off [*3] |-> o_pulse_a[0] == !out_app_ff[OUT_LEVEL_BIT]
      && o_pulse_b[0] == !out_app_ff[OUT_LEVEL_BIT];
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("pulses on off axis");
  property p_both_jog;
    x_both [*4] |-> $stable(o_pulse_a[0]) && $stable(o_pulse_b[0]);
  endproperty
  a_both_jog: assert property (p_both_jog) else $error("moves on both jog");
  c_write: cover property (o_wb_ack && i_wb_we);
  c_speed: cover property ($rose(o_high_speed[0]));
  c_off: cover property (x_off [*3]);
endmodule

bind axis_flags_top axis_flags_assertions #(.SCAN_CYCLES(SCAN_CYCLES), .PULSE_DIV(PULSE_DIV))
  chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
  .o_pulse_a(o_pulse_a), .o_pulse_b(o_pulse_b), .o_high_speed(o_high_speed),
  .o_scan_tick(o_scan_tick));

//--- sim/drive_model.sv
`timescale 1ns/100ps
// Motor drive stand-in: counts steps arriving on its two lines
module drive_model
(
  input wire logic i_clk,
  input wire logic i_line_a, // Clockwise or pulse line
  input wire logic i_line_b, // Counter-clockwise or direction line
  input wire logic i_active_high, // Polarity the drive is set for
  output int o_count_a,
  output int o_count_b
);
  logic a_ff = 1'b1; // Previous line levels
  logic b_ff = 1'b1;
  int na_ff = 0;
  int nb_ff = 0;
  // A step is a change onto the active level
  always_ff @(posedge i_clk)
  begin
    a_ff <= i_line_a;
    b_ff <= i_line_b;
    if (i_line_a == i_active_high && a_ff != i_active_high)
      na_ff <= na_ff + 1;
    if (i_line_b == i_active_high && b_ff != i_active_high)
      nb_ff <= nb_ff + 1;
  end
  assign o_count_a = na_ff;
  assign o_count_b = nb_ff;
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
// Register-level regression of the two-axis flag block
module tb_top;
  import axis_flags_pkg::*;
  localparam int SCAN = 4;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] bus_dat;
  logic ack, tick, step_chg = 1'b0, step_ax = 1'b0, lvl = 1'b0, sync = 1'b1;
  logic [1:0] org = 2'h0, uplim = 2'h0, swl = 2'h0; // Origin, limit pin, soft limit
  logic [15:0] step_val = 16'h0000;
  logic [1:0] done = 2'h0;
  logic [1:0] zero2 = 2'h0;
  logic [1:0] pa, pb, mcode, hs;
  logic [15:0] jcmd [4] = '{16'h2, 16'h4, 16'h6, 16'h0}; // Jog commands
  logic [1:0] jexp [4] = '{2'h2, 2'h1, 2'h0, 2'h0}; // Lines that should step
  int na, nb, k0, k1, mismatches = 0, n_compared = 0;
  always #20 i_clk = ~i_clk;
  axis_flags_top #(.SCAN_CYCLES(SCAN), .PULSE_DIV(2)) dut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(bus_dat), .o_wb_ack(ack),
    .i_step_change(step_chg), .i_step_axis(step_ax), .i_step_value(step_val),
    .i_origin_req(org), .i_step_done(done), .i_sw_limit_hit(swl),
    .i_const_speed(swl), .i_upper_limit_pin(uplim), .i_lower_limit_pin(zero2),
    .o_pulse_a(pa), .o_pulse_b(pb), .o_mcode(mcode), .o_high_speed(hs),
    .o_scan_tick(tick));
  drive_model drive (.i_clk(i_clk), .i_line_a(pa[0]), .i_line_b(pb[0]),
    .i_active_high(lvl), .o_count_a(na), .o_count_b(nb));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle, started just after a scan boundary unless scans are frozen
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk iff (tick === 1'b1 || !sync));
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(negedge i_clk);
    while (ack !== 1'b1 && t < 20)
    begin
      t++;
      @(negedge i_clk);
    end
    if (t == 20)
      mismatches++;
    @(posedge i_clk);
    rdat = bus_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check("register", rdat, e);
  endtask
  task automatic scans(input int n);
    repeat (n * SCAN) @(posedge i_clk);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog far beyond the expected run length
  initial
  begin
    #2000000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rdchk(ADDR_X_CMD, 32'h0);
    wb(1'b1, ADDR_X_STEP, 32'h5);
    rdchk(ADDR_X_STEP, {16'h0, STEP_RESET});
    rdchk(ADDR_AXIS_MASK, 32'h0);
    // Configuration words of both axes keep their own values
    for (int i = 0; i < 6; i++)
      wb(1'b1, 6'(i / 3 * 32 + 4 + i % 3 * 4), 32'hffff_5a00 | 32'(i));
    for (int i = 0; i < 6; i++)
    begin
      rdchk(6'(i / 3 * 32 + 4 + i % 3 * 4), 32'h5a00 | 32'(i));
      wb(1'b1, 6'(i / 3 * 32 + 4 + i % 3 * 4), 32'h0);
    end
    // Step number changes only by the instruction, per axis
    step_ax <= 1'b1;
    step_val <= 16'h0007;
    step_chg <= 1'b1;
    @(posedge i_clk);
    step_chg <= 1'b0;
    rdchk(ADDR_Y_BASE + ADDR_X_STEP, 32'h7);
    rdchk(ADDR_X_STEP, 32'h1);
    // Speed bit shows only after the next scan boundary
    wb(1'b1, ADDR_X_CMD, 32'h8);
    check("speed", 32'(hs), 32'h0);
    @(posedge i_clk iff tick === 1'b1);
    @(negedge i_clk);
    check("speed", 32'(hs), 32'h1);
    // Frozen scans keep the applied flags until released
    sync = 1'b0;
    wb(1'b1, ADDR_SCAN_CTRL, 32'h1);
    wb(1'b1, ADDR_X_CMD, 32'h0);
    scans(3);
    check("frozen speed", 32'(hs), 32'h1);
    rdchk(ADDR_SCAN_CTRL, 32'h1);
    wb(1'b1, ADDR_SCAN_CTRL, 32'h0);
    sync = 1'b1;
    // Jog by level: forward, reverse, both, released
    for (int j = 0; j < 4; j++)
    begin
      wb(1'b1, ADDR_X_CMD, 32'(jcmd[j]));
      scans(3);
      k0 = na;
      k1 = nb;
      scans(8);
      check("jog a", 32'(na != k0), 32'(jexp[j][1]));
      check("jog b", 32'(nb != k1), 32'(jexp[j][0]));
    end
    // Active-high pulse with direction, then disabled axis
    wb(1'b1, ADDR_X_OUT_CFG, 32'ha);
    lvl <= 1'b1;
    wb(1'b1, ADDR_X_CMD, 32'h4);
    scans(3);
    k0 = na;
    k1 = nb;
    scans(8);
    check("pulse", 32'(na != k0), 32'h1);
    check("direction", 32'(pb[0]), 32'h1);
    check("direction steady", 32'(nb - k1), 32'h0);
    wb(1'b1, ADDR_X_OUT_CFG, 32'h3);
    scans(3);
    k0 = na;
    scans(8);
    check("disabled", 32'(na - k0), 32'h0);
    wb(1'b1, ADDR_X_OUT_CFG, 32'h0);
    lvl <= 1'b0;
    // Start edge runs until step done under each M-code mode
    for (int m = 0; m < 3; m++)
    begin
      wb(1'b1, ADDR_X_MCODE_CFG, 32'(m) << MCODE_LSB);
      wb(1'b1, ADDR_X_CMD, 32'h0);
      wb(1'b1, ADDR_X_CMD, 32'h1);
      scans(3);
      k0 = na;
      scans(4);
      check("run", 32'(na != k0), 32'h1);
      check("mcode with", 32'(mcode[0]), 32'(m == 1));
      done <= 2'h1;
      @(posedge i_clk);
      done <= 2'h0;
      scans(3);
      check("mcode after", 32'(mcode[0]), 32'(m == 2));
      k0 = na;
      scans(6);
      check("no restart", 32'(na - k0), 32'h0);
    end
    // Origin search in each configured direction
    for (int d = 0; d < 2; d++)
    begin
      wb(1'b1, ADDR_X_ORIGIN_CFG, 32'(d) << ORIGIN_DIR_BIT);
      scans(1);
      org <= 2'h1;
      scans(2);
      k0 = na;
      k1 = nb;
      scans(4);
      check("origin a", 32'(na != k0), 32'(d == 0));
      check("origin b", 32'(nb != k1), 32'(d == 1));
      org <= 2'h0;
      done <= 2'h1;
      @(posedge i_clk);
      done <= 2'h0;
    end
    // Limit pin blocks jog only while limit use is set
    uplim <= 2'h1;
    wb(1'b1, ADDR_X_OUT_CFG, 32'h4);
    wb(1'b1, ADDR_X_CMD, 32'h2);
    scans(3);
    k0 = na;
    scans(4);
    check("limit stop", 32'(na - k0), 32'h0);
    wb(1'b1, ADDR_X_OUT_CFG, 32'h0);
    scans(2);
    k0 = na;
    scans(4);
    check("limit ignored", 32'(na != k0), 32'h1);
    uplim <= 2'h0;
    // Software limit at constant speed stops a run only when checked
    swl <= 2'h1;
    wb(1'b1, ADDR_X_CMD, 32'h1);
    scans(3);
    k0 = na;
    scans(4);
    check("soft limit skipped", 32'(na != k0), 32'h1);
    wb(1'b1, ADDR_X_MCODE_CFG, 32'h10);
    scans(2);
    k0 = na;
    scans(4);
    check("soft limit stop", 32'(na - k0), 32'h0);
    swl <= 2'h0;
    complete_run();
  end
endmodule
